// ---- hw/jbst_defines.svh ----
// Purpose: Constants of the boundary-scan test access port.
// Assumes: Included by the package, the property module and the bench.
// Notes: Codes are ten bits, shifted in least significant bit first.
// How it works
// - Host drives tdi tms tck trst_n; device tdo.
// - Sample/preload captures pins, preloads pattern.
// - Extest drives pins from scan cells.
// - Bypass gives one-bit, one-stage serial path.
// - User code puts 32-bit code in path.
// - Id code shifts identification value out.
// - High-z selects bypass, floats every pin.
// - Clamp selects bypass, holds pins at cells.
// - Restart code emulates pulsing restart pin low.
// - I/O standard load; aborts running configuration.
// - Status held low until I/O update.
// - Instruction ten bits, user code thirty-two.
// - Keepers and pull-ups override test float.
`ifndef JBST_DEFINES_SVH
`define JBST_DEFINES_SVH

// -----------------------------------------------------------------
// Widths
// -----------------------------------------------------------------
`define JBST_IR_W 10
`define JBST_USER_W 32
`define JBST_PINS 8
`define JBST_IOSTD_W 2

// -----------------------------------------------------------------
// Instruction codes and reset values
// -----------------------------------------------------------------
`define JBST_I_SAMPLE 10'h005
`define JBST_I_EXTEST 10'h00f
`define JBST_I_BYPASS 10'h3ff
`define JBST_I_USER 10'h007
`define JBST_I_IDCODE 10'h006
`define JBST_I_HIGHZ 10'h00b
`define JBST_I_CLAMP 10'h00a
`define JBST_I_RECONF 10'h001
`define JBST_I_IOSTD 10'h00d
`define JBST_IR_CAPT 10'h001
`define JBST_ID_RESET 32'h0000_0001

`endif

// ---- hw/jbst_pkg.sv ----
// Purpose: Types shared by the test access port modules.
// Assumes: Constants come from the defines header.
// Notes: Nothing here is a process.
`include "jbst_defines.svh"
package jbst_pkg;
	// Controller states, written out in hex.
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
		UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
		EX1_IR = 4'hc, PAU_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
	} jbst_tap_state_t;
	// Data register selected between tdi and tdo.
	typedef enum logic [2:0] {
		PATH_BYP = 3'h0, PATH_ID = 3'h1, PATH_USER = 3'h2,
		PATH_BSR = 3'h3, PATH_IOSTD = 3'h4
	} jbst_path_t;
	// Pin synchroniser state: bit 2 tck, bit 1 tms, bit 0 tdi.
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] filt;
		logic rise;
		logic fall;
	} jbst_sync_st_t;
	// Boundary cells: per pin {input, output, enable}.
	typedef struct packed {
		logic [3*`JBST_PINS-1:0] sh;
		logic [3*`JBST_PINS-1:0] upd;
	} jbst_bsr_st_t;
	// Controller state.
	typedef struct packed {
		jbst_tap_state_t st;
		logic [`JBST_IR_W-1:0] ir_sh;
		logic [`JBST_IR_W-1:0] ir;
		logic byp;
		logic [`JBST_USER_W-1:0] dr_sh;
		logic [`JBST_IOSTD_W*`JBST_PINS-1:0] io_sh;
		logic [`JBST_IOSTD_W*`JBST_PINS-1:0] io_std;
		logic tdo;
		logic tdo_oe;
		logic stat_low;
		logic reconf;
		logic abort;
	} jbst_tap_st_t;
endpackage

// ---- hw/jbst_jtag_if.sv ----
// Purpose: Sampled test-port signals shared by the modules.
// Assumes: All members belong to the clk domain.
// Notes: Edges are one-cycle pulses.
`timescale 1ns/1ps
interface jbst_jtag_if;
	logic tck_rise;
	logic tck_fall;
	logic tms;
	logic tdi;
	modport src (output tck_rise, tck_fall, tms, tdi);
	modport snk (input tck_rise, tck_fall, tms, tdi);
endinterface

// ---- hw/jbst_pin_sync.sv ----
// Purpose: Bring tck, tms and tdi into the clk domain.
// Assumes: tck is much slower than clk.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/1ps
module jbst_pin_sync (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Raw test pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	// Sampled view.
	jbst_jtag_if.src jt
);
	jbst_pkg::jbst_sync_st_t r_r; // Registered state.
	jbst_pkg::jbst_sync_st_t r_nxt; // Next state.

	// Stage one feeds only stage two; the filter looks at two and three.
	always_comb begin
		r_nxt = r_r;
		r_nxt.s1 = {tck, tms, tdi};
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		for (int i = 0; i < 3; i++) begin
			if (r_r.s2[i] == r_r.s3[i]) begin
				r_nxt.filt[i] = r_r.s2[i];
			end
		end
		r_nxt.rise = ~r_r.filt[2] & r_nxt.filt[2];
		r_nxt.fall = r_r.filt[2] & ~r_nxt.filt[2];
	end

	// State register.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign jt.tck_rise = r_r.rise;
	assign jt.tck_fall = r_r.fall;
	assign jt.tms = r_r.filt[1];
	assign jt.tdi = r_r.filt[0];
endmodule

// ---- hw/jbst_bsr.sv ----
// Purpose: Boundary-scan cells and the pin multiplexers.
// Assumes: Strobes are one-cycle pulses from the controller.
// Notes: Cell 0 enable bit sits nearest tdo.
`timescale 1ns/1ps
module jbst_bsr (
	// Clock and controller reset.
	input wire logic clk,
	input wire logic rst_n,
	// Serial input.
	jbst_jtag_if.snk jt,
	// Strobes and mode.
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic test_drive,
	input wire logic highz,
	// Core and pad side.
	input wire logic [`JBST_PINS-1:0] core_out,
	input wire logic [`JBST_PINS-1:0] core_oe,
	input wire logic [`JBST_PINS-1:0] pin_in,
	input wire logic [`JBST_PINS-1:0] keeper_en,
	output logic [`JBST_PINS-1:0] pad_out,
	output logic [`JBST_PINS-1:0] pad_oe,
	output logic [`JBST_PINS-1:0] keeper_on,
	// Serial output.
	output logic so
);
	localparam int W = 3 * `JBST_PINS;
	jbst_pkg::jbst_bsr_st_t r_r; // Registered cells.
	jbst_pkg::jbst_bsr_st_t r_nxt; // Next cells.

	// Capture snapshots pins and core; shift moves toward tdo.
	always_comb begin
		r_nxt = r_r;
		if (capture) begin
			for (int i = 0; i < `JBST_PINS; i++) begin
				r_nxt.sh[3*i+2] = pin_in[i];
				r_nxt.sh[3*i+1] = core_out[i];
				r_nxt.sh[3*i] = core_oe[i];
			end
		end else if (shift) begin
			r_nxt.sh = {jt.tdi, r_r.sh[W-1:1]};
		end else if (update) begin
			r_nxt.upd = r_r.sh;
		end
	end

	// Cell registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Pad multiplexers: float beats drive, test beats core.
	always_comb begin
		for (int i = 0; i < `JBST_PINS; i++) begin
			if (highz) begin
				pad_out[i] = 1'b0;
				pad_oe[i] = 1'b0;
			end else if (test_drive) begin
				pad_out[i] = r_r.upd[3*i+1];
				pad_oe[i] = r_r.upd[3*i];
			end else begin
				pad_out[i] = core_out[i];
				pad_oe[i] = core_oe[i];
			end
			// A keeper stays on whenever the pad floats, test or not.
			keeper_on[i] = keeper_en[i] & ~pad_oe[i];
		end
	end

	assign so = r_r.sh[0];
endmodule

// ---- hw/jbst_tap.sv ----
// Purpose: Test access port controller and its data registers.
// Assumes: clk runs far faster than tck; tck, tms and tdi are synchronised here.
// Notes: The controller acts on the sampled rising edge of tck.
`timescale 1ns/1ps
module jbst_tap #(
	// Identification value; arbitrary, lsb kept at one.
	parameter logic [31:0] ID_VALUE = `JBST_ID_RESET
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Test port pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe,
	// Core side of the I/O pins.
	input wire logic [`JBST_PINS-1:0] core_out,
	input wire logic [`JBST_PINS-1:0] core_oe,
	input wire logic [`JBST_PINS-1:0] keeper_en,
	// Pad side of the I/O pins.
	input wire logic [`JBST_PINS-1:0] pin_in,
	output logic [`JBST_PINS-1:0] pad_out,
	output logic [`JBST_PINS-1:0] pad_oe,
	output logic [`JBST_PINS-1:0] keeper_on,
	// Configuration side.
	input wire logic [`JBST_USER_W-1:0] usercode,
	input wire logic config_active,
	output logic config_restart_req,
	output logic config_abort,
	output logic config_status_n_out,
	output logic config_status_n_oe,
	output logic [`JBST_IOSTD_W*`JBST_PINS-1:0] io_std
);
	// -----------------------------------------------------------------
	// Local sizes
	// -----------------------------------------------------------------
	localparam int IW = `JBST_IR_W;
	localparam int UW = `JBST_USER_W;
	localparam int SW = `JBST_IOSTD_W * `JBST_PINS;

	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	jbst_jtag_if jt (); // Sampled test port.
	jbst_pkg::jbst_tap_st_t r_r; // Registered controller state.
	jbst_pkg::jbst_tap_st_t r_nxt; // Next controller state.
	jbst_pkg::jbst_path_t path; // Path of the active instruction.
	logic tap_rst_n; // Controller reset, either source.
	logic bsr_cap; // Boundary capture strobe.
	logic bsr_sh; // Boundary shift strobe.
	logic bsr_upd; // Boundary update strobe.
	logic bsr_so; // Boundary serial out.
	logic test_drive; // Pins follow the update cells.
	logic highz; // Pins float.

	// -----------------------------------------------------------------
	// Functions
	// -----------------------------------------------------------------

	// Sixteen-state walk stepped by tms.
	function automatic jbst_pkg::jbst_tap_state_t step(
		input jbst_pkg::jbst_tap_state_t s,
		input logic m
	);
		jbst_pkg::jbst_tap_state_t t;
		t = s;
		case (s)
			jbst_pkg::TLR: t = m ? jbst_pkg::TLR : jbst_pkg::RTI;
			jbst_pkg::RTI: t = m ? jbst_pkg::SEL_DR : jbst_pkg::RTI;
			jbst_pkg::SEL_DR: t = m ? jbst_pkg::SEL_IR : jbst_pkg::CAP_DR;
			jbst_pkg::CAP_DR: t = m ? jbst_pkg::EX1_DR : jbst_pkg::SH_DR;
			jbst_pkg::SH_DR: t = m ? jbst_pkg::EX1_DR : jbst_pkg::SH_DR;
			jbst_pkg::EX1_DR: t = m ? jbst_pkg::UPD_DR : jbst_pkg::PAU_DR;
			jbst_pkg::PAU_DR: t = m ? jbst_pkg::EX2_DR : jbst_pkg::PAU_DR;
			jbst_pkg::EX2_DR: t = m ? jbst_pkg::UPD_DR : jbst_pkg::SH_DR;
			jbst_pkg::UPD_DR: t = m ? jbst_pkg::SEL_DR : jbst_pkg::RTI;
			jbst_pkg::SEL_IR: t = m ? jbst_pkg::TLR : jbst_pkg::CAP_IR;
			jbst_pkg::CAP_IR: t = m ? jbst_pkg::EX1_IR : jbst_pkg::SH_IR;
			jbst_pkg::SH_IR: t = m ? jbst_pkg::EX1_IR : jbst_pkg::SH_IR;
			jbst_pkg::EX1_IR: t = m ? jbst_pkg::UPD_IR : jbst_pkg::PAU_IR;
			jbst_pkg::PAU_IR: t = m ? jbst_pkg::EX2_IR : jbst_pkg::PAU_IR;
			jbst_pkg::EX2_IR: t = m ? jbst_pkg::UPD_IR : jbst_pkg::SH_IR;
			jbst_pkg::UPD_IR: t = m ? jbst_pkg::SEL_DR : jbst_pkg::RTI;
			default: t = jbst_pkg::TLR;
		endcase
		return t;
	endfunction

	// Maps an instruction to its data path; anything unknown is bypass.
	function automatic jbst_pkg::jbst_path_t path_of(
		input logic [IW-1:0] i
	);
		jbst_pkg::jbst_path_t p;
		p = jbst_pkg::PATH_BYP;
		if (i == `JBST_I_IDCODE) begin
			p = jbst_pkg::PATH_ID;
		end else if (i == `JBST_I_USER) begin
			p = jbst_pkg::PATH_USER;
		end else if (i == `JBST_I_SAMPLE || i == `JBST_I_EXTEST) begin
			p = jbst_pkg::PATH_BSR;
		end else if (i == `JBST_I_IOSTD) begin
			p = jbst_pkg::PATH_IOSTD;
		end
		return p;
	endfunction

	// -----------------------------------------------------------------
	// Pin sampling
	// -----------------------------------------------------------------

	// Three stages and a filter flop per pin; tck edges arrive as one-cycle pulses.
	jbst_pin_sync u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.jt(jt.src)
	);

	// The test reset must act at once, so it is not synchronised.
	// Release may land close to a clk edge; the host keeps tms high
	// across it, and the controller then simply stays in reset.
	assign tap_rst_n = arst_n & trst_n;

	// -----------------------------------------------------------------
	// Instruction decode
	// -----------------------------------------------------------------
	assign path = path_of(r_r.ir);
	// Clamp reuses the extest drive: pins show the update cells.
	assign test_drive = (r_r.ir == `JBST_I_EXTEST) ||
		(r_r.ir == `JBST_I_CLAMP);
	assign highz = (r_r.ir == `JBST_I_HIGHZ);

	// Boundary strobes follow the shared data-register timing.
	assign bsr_cap = jt.tck_rise && path == jbst_pkg::PATH_BSR &&
		r_r.st == jbst_pkg::CAP_DR;
	assign bsr_sh = jt.tck_rise && path == jbst_pkg::PATH_BSR &&
		r_r.st == jbst_pkg::SH_DR;
	assign bsr_upd = jt.tck_rise && path == jbst_pkg::PATH_BSR &&
		r_r.st == jbst_pkg::UPD_DR;

	// -----------------------------------------------------------------
	// Controller next state
	// -----------------------------------------------------------------

	// All register actions happen on the rising tck edge that leaves
	// the named state; tdo moves on the falling edge.
	always_comb begin
		r_nxt = r_r;
		r_nxt.reconf = 1'b0;
		r_nxt.abort = 1'b0;
		if (jt.tck_rise) begin
			r_nxt.st = step(r_r.st, jt.tms);
			case (r_r.st)
				jbst_pkg::TLR: begin
					// Reset leaves the identification path selected.
					r_nxt.ir = `JBST_I_IDCODE;
				end
				jbst_pkg::CAP_IR: begin
					r_nxt.ir_sh = `JBST_IR_CAPT;
				end
				jbst_pkg::SH_IR: begin
					r_nxt.ir_sh = {jt.tdi, r_r.ir_sh[IW-1:1]};
				end
				jbst_pkg::UPD_IR: begin
					r_nxt.ir = r_r.ir_sh;
					if (r_r.ir_sh == `JBST_I_RECONF) begin
						// Internal request only; the pin stays as it is.
						r_nxt.reconf = 1'b1;
					end
					if (r_r.ir_sh == `JBST_I_IOSTD) begin
						r_nxt.stat_low = 1'b1;
						// Loading during configuration stops it.
						r_nxt.abort = config_active;
					end
				end
				jbst_pkg::CAP_DR: begin
					r_nxt.byp = 1'b0;
					if (path == jbst_pkg::PATH_ID) begin
						r_nxt.dr_sh = ID_VALUE;
					end else if (path == jbst_pkg::PATH_USER) begin
						r_nxt.dr_sh = usercode;
					end
				end
				jbst_pkg::SH_DR: begin
					if (path == jbst_pkg::PATH_BYP) begin
						r_nxt.byp = jt.tdi;
					end else if (path == jbst_pkg::PATH_ID ||
						path == jbst_pkg::PATH_USER) begin
						r_nxt.dr_sh = {jt.tdi, r_r.dr_sh[UW-1:1]};
					end else if (path == jbst_pkg::PATH_IOSTD) begin
						r_nxt.io_sh = {jt.tdi, r_r.io_sh[SW-1:1]};
					end
				end
				jbst_pkg::UPD_DR: begin
					if (path == jbst_pkg::PATH_IOSTD) begin
						r_nxt.io_std = r_r.io_sh;
						r_nxt.stat_low = 1'b0;
					end
				end
				default: begin
					// Other states only move the walk.
				end
			endcase
		end
		if (jt.tck_fall) begin
			r_nxt.tdo_oe = 1'b0;
			if (r_r.st == jbst_pkg::SH_IR) begin
				r_nxt.tdo = r_r.ir_sh[0];
				r_nxt.tdo_oe = 1'b1;
			end else if (r_r.st == jbst_pkg::SH_DR) begin
				r_nxt.tdo_oe = 1'b1;
				case (path)
					jbst_pkg::PATH_ID: r_nxt.tdo = r_r.dr_sh[0];
					jbst_pkg::PATH_USER: r_nxt.tdo = r_r.dr_sh[0];
					jbst_pkg::PATH_BSR: r_nxt.tdo = bsr_so;
					jbst_pkg::PATH_IOSTD: r_nxt.tdo = r_r.io_sh[0];
					default: r_nxt.tdo = r_r.byp;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// Controller register
	// -----------------------------------------------------------------

	// Either reset puts the controller in Test-Logic-Reset at once.
	always_ff @(posedge clk or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			r_r <= '0;
			r_r.st <= jbst_pkg::TLR;
			r_r.ir <= `JBST_I_IDCODE;
		end else begin
			r_r <= r_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Boundary-scan cells
	// -----------------------------------------------------------------

	// Cells and pad multiplexers; extest and sample share the chain.
	jbst_bsr u_bsr (
		.clk(clk),
		.rst_n(tap_rst_n),
		.jt(jt.snk),
		.capture(bsr_cap),
		.shift(bsr_sh),
		.update(bsr_upd),
		.test_drive(test_drive),
		.highz(highz),
		.core_out(core_out),
		.core_oe(core_oe),
		.pin_in(pin_in),
		.keeper_en(keeper_en),
		.pad_out(pad_out),
		.pad_oe(pad_oe),
		.keeper_on(keeper_on),
		.so(bsr_so)
	);

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign tdo = r_r.tdo;
	assign tdo_oe = r_r.tdo_oe;
	assign config_restart_req = r_r.reconf;
	assign config_abort = r_r.abort;
	// Open drain: only ever pulls low.
	assign config_status_n_out = 1'b0;
	assign config_status_n_oe = r_r.stat_low;
	assign io_std = r_r.io_std;
endmodule

// ---- tb/jbst_tap_properties.sv ----
// Purpose: Port-level properties of the test access port.
// Assumes: tck idles low; tck phases last far longer than 5 clk.
// Notes: Strobes are tied to the sampled tck level that causes them.
`timescale 1ns/1ps
`include "jbst_defines.svh"
module jbst_tap_properties (
	// Clock and resets.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic trst_n,
	// Test port.
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe,
	// Pins.
	input wire logic [`JBST_PINS-1:0] core_out,
	input wire logic [`JBST_PINS-1:0] core_oe,
	input wire logic [`JBST_PINS-1:0] keeper_en,
	input wire logic [`JBST_PINS-1:0] pad_out,
	input wire logic [`JBST_PINS-1:0] pad_oe,
	input wire logic [`JBST_PINS-1:0] keeper_on,
	// Configuration side.
	input wire logic config_active,
	input wire logic config_restart_req,
	input wire logic config_abort,
	input wire logic config_status_n_out,
	input wire logic config_status_n_oe,
	input wire logic [`JBST_IOSTD_W*`JBST_PINS-1:0] io_std
);
	default clocking cb @(posedge clk); endclocking
	// Either reset returns the port to a known state.
	default disable iff (!arst_n || !trst_n);
	// A strobe is high for exactly one clk.
	sequence s_one_clk(logic s);
		s ##1 !s;
	endsequence
	// Serial outputs move only after tck has been low for a while.
	sequence s_tck_low;
		!$past(tck, 2) && !tck;
	endsequence
	a_keeper_wins: assert property (
		keeper_on == (keeper_en & ~pad_oe))
		else $error("keeper view does not follow the float state");
	a_restart_single: assert property (
		config_restart_req |-> tck ##0 s_one_clk(config_restart_req))
		else $error("restart request is not a single pulse on tck high");
	a_abort_single: assert property (
		config_abort |-> tck ##0 s_one_clk(config_abort))
		else $error("abort is not a single pulse on tck high");
	a_abort_when_busy: assert property (
		config_abort |-> $past(config_active))
		else $error("abort raised while no configuration ran");
	a_abort_holds_status: assert property (
		config_abort |-> ##[0:1] config_status_n_oe)
		else $error("status not pulled low on abort");
	a_status_open_drain: assert property (
		config_status_n_out == 1'b0)
		else $error("status data is not low");
	a_status_release: assert property (
		$fell(config_status_n_oe) |-> tck && $changed(io_std))
		else $error("status released without an update");
	a_io_std_load: assert property (
		$changed(io_std) |-> $fell(config_status_n_oe))
		else $error("I/O standard changed outside its update");
	a_tdo_on_fall: assert property (
		$changed(tdo) || $changed(tdo_oe) |-> s_tck_low)
		else $error("serial output moved while tck was high");
	a_trst_pads: assert property (
		$rose(trst_n) |-> pad_out == core_out && pad_oe == core_oe)
		else $error("pads not returned to the core after test reset");
endmodule
bind jbst_tap jbst_tap_properties jbst_tap_properties_i (
	.clk(clk), .arst_n(arst_n), .trst_n(trst_n), .tck(tck), .tdo(tdo),
	.tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
	.keeper_en(keeper_en), .pad_out(pad_out), .pad_oe(pad_oe),
	.keeper_on(keeper_on), .config_active(config_active),
	.config_restart_req(config_restart_req), .config_abort(config_abort),
	.config_status_n_out(config_status_n_out),
	.config_status_n_oe(config_status_n_oe), .io_std(io_std)
);

// ---- tb/jbst_host.sv ----
// Purpose: Test host model that walks the controller through scans.
// Assumes: The controller rests in Run-Test/Idle between scans.
// Notes: tck stops low between frames; tms and tdi rest high.
`timescale 1ns/1ps
module jbst_host #(
	// Half period of tck; 40 ns gives the 80 ns link clock.
	parameter realtime HALF = 40.0
) (
	// Bench clock, used only to place pin changes just after its edge.
	input wire logic clk,
	// Test port pins.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// Idle levels follow the pin pull-downs and pull-ups.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One tck period; tdo is taken just before the rising edge.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#(HALF);
		q = tdo;
		tck = 1'b1;
		#(HALF);
		tck = 1'b0;
	endtask
	// From Test-Logic-Reset or idle into idle.
	task automatic idle();
		logic q;
		@(posedge clk);
		#1;
		step(1'b0, 1'b1, q);
		tms = 1'b1;
	endtask
	// Full IR or DR scan of n bits, lsb first, ending in idle.
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		// Half periods are whole clk periods, so every change stays 1 ns
		// after a clk edge and never races the pin samplers.
		@(posedge clk);
		#1;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		tms = 1'b1;
		tdi = 1'b1;
	endtask
endmodule

// ---- tb/jbst_tap_tb.sv ----
// Purpose: Self-checking bench for the test access port.
// Assumes: The host model drives the test pins at an 80 ns tck.
// Notes: Each scenario judges its own results before returning.
`timescale 1ns/1ps
`include "jbst_defines.svh"
module jbst_tap_tb;
	localparam logic [31:0] ID = 32'h1234_5679; // Arbitrary, lsb one.
	localparam int LIMIT = 30000; // The run needs about 8100 clk.
	localparam logic [23:0] PAT = 24'h6b2c93;
	localparam logic [9:0] CODES [5] = '{10'h3ff, 10'h00b, 10'h00a,
		10'h155, 10'h200};
	logic clk, arst_n, trst_n, tck, tms, tdi, tdo, tdo_oe;
	logic [7:0] core_out, core_oe, keeper_en, pin_in, pad_out, pad_oe;
	logic [7:0] keeper_on;
	logic [31:0] usercode, q;
	logic config_active, restart_req, abort, status_out, status_oe;
	logic [15:0] io_std;
	// A released tdo shows the inverse, so a sample outside shift fails.
	logic tdo_seen;
	assign tdo_seen = tdo_oe ? tdo : ~tdo;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n_restart = 0;
	int n_abort = 0;
	jbst_tap #(.ID_VALUE(ID)) jbst_tap_i (.clk(clk), .arst_n(arst_n),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
		.keeper_en(keeper_en), .pin_in(pin_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .keeper_on(keeper_on), .usercode(usercode),
		.config_active(config_active), .config_restart_req(restart_req),
		.config_abort(abort), .config_status_n_out(status_out),
		.config_status_n_oe(status_oe), .io_std(io_std));
	jbst_host jbst_host_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo_seen));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	// Pulse counters and the hang guard. They look on the falling edge,
	// half a period away from the edge that launches each pulse.
	always @(negedge clk) begin
		cyc++;
		if (restart_req === 1'b1)
			n_restart++;
		if (abort === 1'b1)
			n_abort++;
		if (cyc == LIMIT) begin
			errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic done(input string name);
		$display("test %s finished, mismatches so far %0d", name, errors);
	endtask
	// IR load; the capture pattern must come out first.
	task automatic ir(input logic [9:0] code);
		jbst_host_i.scan(1'b1, 10, {22'h0, code}, q);
		chk({22'h0, q[9:0]}, 32'h001);
	endtask
	task automatic dr(input int n, input logic [31:0] d);
		jbst_host_i.scan(1'b0, n, d, q);
	endtask
	// Boundary cell image: per pin {pin, out, oe}, oe lowest.
	function automatic logic [23:0] cells(input logic [7:0] p,
		input logic [7:0] o, input logic [7:0] e);
		for (int i = 0; i < 8; i++)
			cells[3*i +: 3] = {p[i], o[i], e[i]};
	endfunction
	// Pads {out, oe} that a cell image drives.
	function automatic logic [31:0] drive(input logic [23:0] c);
		drive = '0;
		for (int i = 0; i < 8; i++) begin
			drive[8+i] = c[3*i+1];
			drive[i] = c[3*i];
		end
	endfunction
	task automatic t_ident();
		dr(32, 32'h0);
		chk(q, ID);
		chk({31'h0, tdo_oe}, 32'h0);
		ir(`JBST_I_IDCODE);
		dr(32, 32'h0);
		chk(q, ID);
		ir(`JBST_I_USER);
		dr(32, 32'h0);
		chk(q, usercode);
		done("ident");
	endtask
	task automatic t_bsr();
		ir(`JBST_I_SAMPLE);
		dr(24, {8'h0, PAT});
		chk({8'h0, q[23:0]}, {8'h0, cells(pin_in, core_out, core_oe)});
		chk({16'h0, pad_out, pad_oe}, {16'h0, core_out, core_oe});
		ir(`JBST_I_EXTEST);
		chk({16'h0, pad_out, pad_oe}, drive(PAT));
		dr(24, {8'h0, ~PAT});
		chk({8'h0, q[23:0] & 24'h924924},
			{8'h0, cells(pin_in, 8'h0, 8'h0)});
		chk({16'h0, pad_out, pad_oe}, drive(~PAT));
		done("boundary");
	endtask
	task automatic t_bypass();
		for (int k = 0; k < 5; k++) begin
			ir(CODES[k]);
			dr(4, 32'hb);
			chk({28'h0, q[3:0]}, 32'h6);
			if (CODES[k] == `JBST_I_HIGHZ)
				chk({16'h0, pad_oe, keeper_on}, {24'h0, keeper_en});
			else if (CODES[k] == `JBST_I_CLAMP)
				chk({16'h0, pad_out, pad_oe}, drive(~PAT));
			else
				chk({16'h0, pad_out, pad_oe}, {16'h0, core_out, core_oe});
		end
		done("bypass");
	endtask
	task automatic t_config();
		int r0, a0;
		r0 = n_restart;
		a0 = n_abort;
		ir(`JBST_I_RECONF);
		chk(32'(n_restart - r0), 32'h1);
		@(posedge clk);
		#1 config_active = 1'b1;
		ir(`JBST_I_IOSTD);
		chk(32'(n_abort - a0), 32'h1);
		chk({31'h0, status_oe}, 32'h1);
		@(posedge clk);
		#1 config_active = 1'b0;
		dr(16, 32'h9c3e);
		chk({16'h0, io_std}, 32'h9c3e);
		chk({31'h0, status_oe}, 32'h0);
		ir(`JBST_I_IOSTD);
		chk(32'(n_abort - a0), 32'h1);
		dr(16, 32'h0);
		chk({16'h0, io_std}, 32'h0);
		done("config");
	endtask
	task automatic t_trst();
		ir(`JBST_I_CLAMP);
		@(posedge clk);
		#1 trst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 trst_n = 1'b1;
		chk({16'h0, pad_out, pad_oe}, {16'h0, core_out, core_oe});
		jbst_host_i.idle();
		dr(32, 32'h0);
		chk(q, ID);
		done("test reset");
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		trst_n = 1'b1;
		core_out = 8'h5a;
		core_oe = 8'h3c;
		keeper_en = 8'hf0;
		pin_in = 8'ha5;
		usercode = 32'hc0de_1234;
		config_active = 1'b0;
		repeat (20) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clk);
		jbst_host_i.idle();
		t_ident();
		t_bsr();
		t_bypass();
		t_config();
		t_trst();
		results();
	end
endmodule
